// ---- src/usc_pkg.sv ----
/*
 * usc_pkg: register map, field positions, reset values and mode constants
 * of the serial transceiver (baud clock generation and receive buffering).
 * Assumes a 32-bit classic Wishbone register bus, one register per word.
 */
package usc_pkg;

	// register byte offsets
	localparam logic [7:0] USC_OFF_DATA = 8'h00;
	localparam logic [7:0] USC_OFF_CSA = 8'h04;
	localparam logic [7:0] USC_OFF_CSB = 8'h08;
	localparam logic [7:0] USC_OFF_CSC = 8'h0C;
	localparam logic [7:0] USC_OFF_BAUD_LO = 8'h10;
	localparam logic [7:0] USC_OFF_BAUD_HI = 8'h14;
	localparam logic [7:0] USC_OFF_PINDIR = 8'h18;

	// ctrl_status_a fields
	localparam int USC_CSA_RX_READY = 7;
	localparam int USC_CSA_TX_EMPTY = 5;
	localparam int USC_CSA_FRAME_ERR = 4;
	localparam int USC_CSA_OVERRUN = 3;
	localparam int USC_CSA_DOUBLE = 1;

	// ctrl_status_b fields
	localparam int USC_CSB_RX_EN = 4;
	localparam int USC_CSB_TX_EN = 3;
	localparam int USC_CSB_NINE = 2;
	localparam int USC_CSB_RX9 = 1;
	localparam int USC_CSB_TX9 = 0;

	// ctrl_status_c and pin direction fields
	localparam int USC_CSC_SYNC = 6;
	localparam int USC_PINDIR_XCK = 0;

	// reset values
	localparam logic [11:0] USC_RST_BAUD = 12'h000;
	localparam logic USC_RST_BIT = 1'b0;

	// oversampling: last index of the per-bit tick count
	localparam logic [3:0] USC_OS_LAST_NORM = 4'hF;
	localparam logic [3:0] USC_OS_LAST_DBL = 4'h7;

	// frame lengths: transmit in line bits, receive in data bits
	localparam logic [3:0] USC_TX_BITS_8 = 4'hA;
	localparam logic [3:0] USC_TX_BITS_9 = 4'hB;
	localparam logic [3:0] USC_RX_DATA_8 = 4'h8;
	localparam logic [3:0] USC_RX_DATA_9 = 4'h9;

	// receive fifo
	localparam logic [1:0] USC_FIFO_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		USC_RX_IDLE = 2'b00,
		USC_RX_START = 2'b01,
		USC_RX_DATA = 2'b10,
		USC_RX_STOP = 2'b11
	} usc_rx_state_t;

	typedef enum logic {
		USC_TX_IDLE = 1'b0,
		USC_TX_SEND = 1'b1
	} usc_tx_state_t;

endpackage

// ---- src/usc_sync2.sv ----
/*
 * usc_sync2: two flip-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to clk_i; output is safe to decode.
 */
`timescale 1ns/1ns
module usc_sync2 (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rst_val_i,
	input wire logic pin_i,
	output logic sync_o
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= rst_val_i;
			sync_o <= rst_val_i;
		end else begin
			meta_q <= pin_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ---- src/usc_core.sv ----
/*
 * usc_core: serial transceiver with baud clock generation, asynchronous and
 * synchronous modes, nine-bit frames and a two-entry receive fifo.
 * Assumes a classic Wishbone master on clk_i and line pins from outside.
 */
// Overview of operation
// - two-entry circular receive fifo, read pops one
// - frame error, overrun, ninth bit ride with character
// - full fifo: shift register holds until start
// - four clock modes, sync select chooses sync
// - pin direction picks master or slave clock
// - clock pin unused in asynchronous modes
// - rate is clock over K times divisor+1
// - double speed cuts prescale sixteen to eight
// - double speed receiver samples once, at tick three of eight
// - external clock synchronised then edge detected
// - sample and change on opposite clock edges
// - received ninth bit at status bit one
// - transmitted ninth bit from status bit zero
`timescale 1ns/1ns
module usc_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rxd_i,
	output logic txd_o,
	input wire logic xck_i,
	output logic xck_o,
	output logic xck_oe_n_o
);
	import usc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register bus
	logic ack_q;
	logic access;
	logic wr_en;
	logic rd_data_pop;
	logic [31:0] rdata;
	logic [11:0] baud_divisor_q;
	logic sync_mode_select_q;
	logic double_speed_bit_q;
	logic serial_clock_pin_direction_q;
	logic nine_q;
	logic rx_en_q;
	logic tx_en_q;
	logic tx_ninth_bit_q;
	logic [7:0] tx_buf_q;
	logic tx_buf9_q;
	logic tx_full_q;
	logic [10:0] fifo_q [2];
	logic fifo_wr_q;
	logic fifo_rd_q;
	logic [1:0] fifo_cnt_q;
	logic [10:0] head;

	// a request is taken at the edge where ack is seen high
	assign access = wb_cyc_i & wb_stb_i & ack_q;
	assign wr_en = access & wb_we_i & wb_sel_i[0];
	assign rd_data_pop = access & ~wb_we_i & (wb_adr_i == USC_OFF_DATA) & (fifo_cnt_q != 2'h0);
	assign wb_ack_o = ack_q;
	assign head = fifo_q[fifo_rd_q];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (wb_adr_i)
			USC_OFF_DATA: rdata[7:0] = head[7:0];
			USC_OFF_CSA: begin
				rdata[USC_CSA_RX_READY] = fifo_cnt_q != 2'h0;
				rdata[USC_CSA_TX_EMPTY] = ~tx_full_q;
				rdata[USC_CSA_FRAME_ERR] = head[9];
				rdata[USC_CSA_OVERRUN] = head[10];
				rdata[USC_CSA_DOUBLE] = double_speed_bit_q;
			end
			USC_OFF_CSB: begin
				rdata[USC_CSB_RX_EN] = rx_en_q;
				rdata[USC_CSB_TX_EN] = tx_en_q;
				rdata[USC_CSB_NINE] = nine_q;
				rdata[USC_CSB_RX9] = head[8];
				rdata[USC_CSB_TX9] = tx_ninth_bit_q;
			end
			USC_OFF_CSC: rdata[USC_CSC_SYNC] = sync_mode_select_q;
			USC_OFF_BAUD_LO: rdata[7:0] = baud_divisor_q[7:0];
			USC_OFF_BAUD_HI: rdata[3:0] = baud_divisor_q[11:8];
			USC_OFF_PINDIR: rdata[USC_PINDIR_XCK] = serial_clock_pin_direction_q;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// read data is launched together with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
			wb_dat_o <= rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_divisor_q <= USC_RST_BAUD;
			sync_mode_select_q <= USC_RST_BIT;
			double_speed_bit_q <= USC_RST_BIT;
			serial_clock_pin_direction_q <= USC_RST_BIT;
			nine_q <= USC_RST_BIT;
			rx_en_q <= USC_RST_BIT;
			tx_en_q <= USC_RST_BIT;
			tx_ninth_bit_q <= USC_RST_BIT;
		end else if (wr_en) begin
			case (wb_adr_i)
				USC_OFF_CSA: double_speed_bit_q <= wb_dat_i[USC_CSA_DOUBLE];
				USC_OFF_CSB: begin
					rx_en_q <= wb_dat_i[USC_CSB_RX_EN];
					tx_en_q <= wb_dat_i[USC_CSB_TX_EN];
					nine_q <= wb_dat_i[USC_CSB_NINE];
					tx_ninth_bit_q <= wb_dat_i[USC_CSB_TX9];
				end
				USC_OFF_CSC: sync_mode_select_q <= wb_dat_i[USC_CSC_SYNC];
				USC_OFF_BAUD_LO: baud_divisor_q[7:0] <= wb_dat_i[7:0];
				USC_OFF_BAUD_HI: baud_divisor_q[11:8] <= wb_dat_i[3:0];
				USC_OFF_PINDIR: serial_clock_pin_direction_q <= wb_dat_i[USC_PINDIR_XCK];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock generation
	logic [11:0] base_cnt_q;
	logic base_tick;
	logic xck_m_q;
	logic xck_s2;
	logic xck_s3_q;
	logic rxd_s;
	logic master;
	logic slave;
	logic sck_rise;
	logic sck_fall;
	logic [3:0] os_last;
	logic [3:0] os_half;

	usc_sync2 u_xck_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rst_val_i(1'b1),
		.pin_i(xck_i),
		.sync_o(xck_s2)
	);

	usc_sync2 u_rxd_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rst_val_i(1'b1),
		.pin_i(rxd_i),
		.sync_o(rxd_s)
	);

	assign base_tick = base_cnt_q == 12'h000;
	assign master = sync_mode_select_q & serial_clock_pin_direction_q;
	assign slave = sync_mode_select_q & ~serial_clock_pin_direction_q;
	assign os_last = double_speed_bit_q ? USC_OS_LAST_DBL : USC_OS_LAST_NORM;
	assign os_half = {1'b0, os_last[3:1]};

	// divide by divisor+1; master toggles the pin per tick, giving 2(n+1)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_cnt_q <= USC_RST_BAUD;
		end else if (base_tick) begin
			base_cnt_q <= baud_divisor_q;
		end else begin
			base_cnt_q <= base_cnt_q - 12'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xck_m_q <= 1'b0;
			xck_s3_q <= 1'b1;
		end else begin
			xck_m_q <= master ? (xck_m_q ^ base_tick) : 1'b0;
			xck_s3_q <= xck_s2;
		end
	end

	// edge detector sits behind the synchroniser: two clocks of latency
	always_comb begin
		sck_rise = 1'b0;
		sck_fall = 1'b0;
		if (master) begin
			sck_rise = base_tick & ~xck_m_q;
			sck_fall = base_tick & xck_m_q;
		end else if (slave) begin
			sck_rise = xck_s2 & ~xck_s3_q;
			sck_fall = ~xck_s2 & xck_s3_q;
		end
	end

	assign xck_o = xck_m_q;
	assign xck_oe_n_o = ~master;

	////////////////////////////////////////////////////////////////////////
	// transmitter
	usc_tx_state_t tx_state_q;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_bits_q;
	logic [3:0] tx_os_q;
	logic tx_step;
	logic tx_load;

	// in sync mode data changes on the falling edge, opposite to sampling
	assign tx_step = sync_mode_select_q ? sck_fall
		: (base_tick & (tx_os_q == os_last));
	assign tx_load = (tx_state_q == USC_TX_IDLE) & tx_full_q & tx_en_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_full_q <= 1'b0;
			tx_buf_q <= 8'h00;
			tx_buf9_q <= 1'b0;
		end else if (wr_en & (wb_adr_i == USC_OFF_DATA)) begin
			tx_full_q <= 1'b1;
			tx_buf_q <= wb_dat_i[7:0];
			tx_buf9_q <= tx_ninth_bit_q;
		end else if (tx_load) begin
			tx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_q <= USC_TX_IDLE;
			tx_sh_q <= 11'h7FF;
			tx_bits_q <= 4'h0;
			tx_os_q <= 4'h0;
		end else begin
			case (tx_state_q)
				USC_TX_IDLE: begin
					if (tx_load) begin
						tx_state_q <= USC_TX_SEND;
						tx_sh_q <= {1'b1, nine_q ? tx_buf9_q : 1'b1, tx_buf_q, 1'b0};
						tx_bits_q <= nine_q ? USC_TX_BITS_9 : USC_TX_BITS_8;
						tx_os_q <= 4'h0;
					end
				end
				USC_TX_SEND: begin
					if (base_tick) begin
						tx_os_q <= (tx_os_q == os_last) ? 4'h0 : tx_os_q + 4'h1;
					end
					if (tx_step) begin
						tx_sh_q <= {1'b1, tx_sh_q[10:1]};
						tx_bits_q <= tx_bits_q - 4'h1;
						if (tx_bits_q == 4'h1) begin
							tx_state_q <= USC_TX_IDLE;
						end
					end
				end
				default: tx_state_q <= USC_TX_IDLE;
			endcase
		end
	end

	assign txd_o = (tx_state_q == USC_TX_SEND) ? tx_sh_q[0] : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// receiver
	usc_rx_state_t rx_state_q;
	logic [3:0] rx_os_q;
	logic [3:0] rx_bits_q;
	logic [8:0] rx_sh_q;
	logic rx_sample;
	logic start_det;
	logic rx_done;
	logic [10:0] rx_word;
	logic hold_v_q;
	logic [10:0] hold_w_q;
	logic pend_dor_q;
	logic fifo_space;
	logic push;
	logic [10:0] push_w;
	logic direct;

	// sampling on the rising edge in sync mode, mid-bit otherwise
	assign rx_sample = sync_mode_select_q ? sck_rise : (base_tick & (rx_os_q == os_half));
	assign start_det = (rx_state_q == USC_RX_IDLE) & rx_en_q & ~rxd_s
		& (sync_mode_select_q ? sck_rise : base_tick);
	assign rx_done = (rx_state_q == USC_RX_STOP) & rx_sample;
	assign rx_word = {pend_dor_q, ~rxd_s, nine_q ? rx_sh_q[8] : 1'b0,
		nine_q ? rx_sh_q[7:0] : rx_sh_q[8:1]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_q <= USC_RX_IDLE;
			rx_os_q <= 4'h0;
			rx_bits_q <= 4'h0;
			rx_sh_q <= 9'h000;
		end else begin
			if (rx_state_q == USC_RX_IDLE) begin
				rx_os_q <= 4'h0;
			end else if (base_tick) begin
				rx_os_q <= (rx_os_q == os_last) ? 4'h0 : rx_os_q + 4'h1;
			end
			case (rx_state_q)
				USC_RX_IDLE: begin
					if (start_det) begin
						rx_state_q <= sync_mode_select_q ? USC_RX_DATA : USC_RX_START;
						rx_bits_q <= nine_q ? USC_RX_DATA_9 : USC_RX_DATA_8;
					end
				end
				USC_RX_START: begin
					if (rx_sample) begin
						rx_state_q <= rxd_s ? USC_RX_IDLE : USC_RX_DATA;
					end
				end
				USC_RX_DATA: begin
					if (rx_sample) begin
						rx_sh_q <= {rxd_s, rx_sh_q[8:1]};
						rx_bits_q <= rx_bits_q - 4'h1;
						if (rx_bits_q == 4'h1) begin
							rx_state_q <= USC_RX_STOP;
						end
					end
				end
				USC_RX_STOP: begin
					if (rx_sample) begin
						rx_state_q <= USC_RX_IDLE;
					end
				end
				default: rx_state_q <= USC_RX_IDLE;
			endcase
		end
	end

	assign fifo_space = fifo_cnt_q != USC_FIFO_DEPTH;
	assign direct = rx_done & ~hold_v_q & fifo_space;

	always_comb begin
		push = 1'b0;
		push_w = rx_word;
		if (hold_v_q & fifo_space) begin
			push = 1'b1;
			push_w = hold_w_q;
		end else if (direct) begin
			push = 1'b1;
		end
	end

	// the shift register is the third level until the next start bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_v_q <= 1'b0;
			hold_w_q <= 11'h000;
			pend_dor_q <= 1'b0;
		end else begin
			if (rx_done & ~direct) begin
				hold_v_q <= 1'b1;
				hold_w_q <= rx_word;
			end else if (hold_v_q & fifo_space) begin
				hold_v_q <= 1'b0;
			end else if (hold_v_q & start_det) begin
				hold_v_q <= 1'b0;
			end
			// overrun rides with the next character that arrives
			if (hold_v_q & ~fifo_space & start_det) begin
				pend_dor_q <= 1'b1;
			end else if (rx_done) begin
				pend_dor_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_q[0] <= 11'h000;
			fifo_q[1] <= 11'h000;
			fifo_wr_q <= 1'b0;
			fifo_rd_q <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else begin
			if (push) begin
				fifo_q[fifo_wr_q] <= push_w;
				fifo_wr_q <= ~fifo_wr_q;
			end
			if (rd_data_pop) begin
				fifo_rd_q <= ~fifo_rd_q;
			end
			fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, rd_data_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		fifo_cnt_q <= USC_FIFO_DEPTH) else $error("fifo count above two");
	chk_pop_one: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_data_pop & ~push |=> fifo_cnt_q == $past(fifo_cnt_q) - 2'h1)
		else $error("data read did not pop one entry");
	chk_flags_ride: assert property (@(posedge clk_i) disable iff (rst_i)
		push & (fifo_cnt_q == 2'h0) |=> head == $past(push_w))
		else $error("flags not stored with character");
	chk_third_level: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_done & ~fifo_space & ~hold_v_q |=> hold_v_q && hold_w_q == $past(rx_word))
		else $error("character lost while fifo full");
	chk_pin_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		~sync_mode_select_q |-> xck_oe_n_o && ~sck_rise && ~sck_fall)
		else $error("clock pin active in async mode");
	chk_master_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		master |-> ~xck_oe_n_o) else $error("master not driving clock pin");
	chk_baud_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		base_tick |=> base_cnt_q == $past(baud_divisor_q))
		else $error("baud divider reload wrong");
	chk_os_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_os_q <= os_last ##1 $stable(double_speed_bit_q) |-> rx_os_q <= os_last)
		else $error("oversample count past its limit");
	chk_edge_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		slave & $rose(xck_i) ##1 slave & xck_i ##1 slave |-> sck_rise)
		else $error("external clock edge not seen two clocks later");
	chk_edges_apart: assert property (@(posedge clk_i) disable iff (rst_i)
		sync_mode_select_q |-> ~(sck_rise & sck_fall))
		else $error("sample and change on the same edge");
	// in sync mode a frame in flight may only move its line bit on the falling clock edge
	chk_tx_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		sync_mode_select_q & (tx_state_q == USC_TX_SEND) & ~sck_fall |=> $stable(txd_o))
		else $error("transmit data changed off the falling edge");
	chk_tx_ninth: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_load & nine_q |=> tx_sh_q[9] == $past(tx_buf9_q))
		else $error("ninth bit not taken into frame");
endmodule

// ---- testbench/usc_far_end.sv ----
/*
 * usc_far_end: remote serial station that sends frames into the receive pin,
 * asynchronous or with its own serial clock (slave clocking of the core).
 * Assumes clk_i is the core's system clock; its serial clock idles low.
 */
`timescale 1ns/1ns
module usc_far_end (
	input wire logic clk_i,
	output logic rxd_o,
	output logic xck_o
);
	initial begin
		rxd_o = 1'b1;
		xck_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// a bad stop bit is cut short so the idle line does not look like a new start
	task automatic send_async(input logic [8:0] val, input int nbits, input int per,
		input logic stop);
		for (int i = 0; i < nbits + 2; i++) begin
			@(posedge clk_i);
			rxd_o <= (i == 0) ? 1'b0 : (i > nbits) ? stop : val[i - 1];
			repeat (((i > nbits) && !stop) ? per * 5 / 8 : per - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (per) @(posedge clk_i);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// data changes on the falling clock edge, the core samples on the rising one
	task automatic send_sync(input logic [7:0] val, input int half);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			xck_o <= 1'b0;
			rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : val[i - 1];
			repeat (half - 1) @(posedge clk_i);
			@(posedge clk_i);
			xck_o <= 1'b1;
			repeat (half - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		xck_o <= 1'b0;
		repeat (4 * half) @(posedge clk_i);
	endtask
endmodule

// ---- testbench/tb_top.sv ----
/*
 * tb_top: self-checking bench for usc_core over classic Wishbone, with a
 * remote serial station on the line pins. Assumes a 50 MHz system clock.
 */
`timescale 1ns/1ns
module tb_top;
	import usc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack, txd, xck_o, xck_oe_n, far_rxd, far_xck, xck_line;
	int err_count = 0;
	int tests_run = 0;
	always #10 clk_i = ~clk_i;
	assign xck_line = xck_oe_n ? far_xck : xck_o;
	usc_core usc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rxd_i(far_rxd),
		.txd_o(txd), .xck_i(xck_line), .xck_o(xck_o), .xck_oe_n_o(xck_oe_n));
	usc_far_end usc_far_end_inst (.clk_i(clk_i), .rxd_o(far_rxd), .xck_o(far_xck));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		wb_sel <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_rdat;
		if (n >= 50) err_count++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		logic [31:0] rd;
		wb_xfer(1'b1, adr, wd, rd);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask,
		input logic [31:0] exp);
		logic [31:0] rd;
		wb_xfer(1'b0, adr, 32'h0, rd);
		chk(rd & mask, exp);
	endtask
	// samples each line bit near its middle; a wrong prescale drifts off the bits
	task automatic tx_chk(input logic [8:0] val, input int nbits, input int per);
		int n;
		logic b;
		n = 0;
		while (txd !== 1'b0 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		repeat (per / 2) @(posedge clk_i);
		for (int i = 0; i < nbits + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : val[i - 1];
			chk({31'h0, txd}, {31'h0, b});
			repeat (per) @(posedge clk_i);
		end
	endtask
	task automatic wait_xck(input logic v, inout int n);
		do begin
			@(posedge clk_i);
			n++;
		end while (xck_o !== v && n < 100);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		logic [7:0] offs [5];
		int n, m;
		offs = '{USC_OFF_CSB, USC_OFF_CSC, USC_OFF_BAUD_LO, USC_OFF_BAUD_HI, USC_OFF_PINDIR};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(USC_OFF_CSA, 32'hDF, 32'h0);
		foreach (offs[i]) rd_chk(offs[i], 32'hFF, 32'h0);
		chk({30'h0, txd, xck_oe_n}, 32'h3);
		wr(8'h1C, 32'hFF);
		rd_chk(8'h1C, 32'hFFFFFFFF, 32'h0);
		// divisor 1: async bit is 16 * 2 clocks
		wr(USC_OFF_BAUD_LO, 32'h01);
		wr(USC_OFF_CSB, 32'h18);
		wr(USC_OFF_DATA, 32'hA5);
		tx_chk(9'h0A5, 8, 32);
		// fifo full plus shift stage; the fourth start drops the third character
		usc_far_end_inst.send_async(9'h03C, 8, 32, 1'b1);
		usc_far_end_inst.send_async(9'h05A, 8, 32, 1'b1);
		usc_far_end_inst.send_async(9'h096, 8, 32, 1'b1);
		usc_far_end_inst.send_async(9'h00F, 8, 32, 1'b1);
		rd_chk(USC_OFF_CSA, 32'h98, 32'h80);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'h3C);
		rd_chk(USC_OFF_CSA, 32'h98, 32'h80);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'h5A);
		rd_chk(USC_OFF_CSA, 32'h98, 32'h88);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'h0F);
		rd_chk(USC_OFF_CSA, 32'h80, 32'h0);
		usc_far_end_inst.send_async(9'h081, 8, 32, 1'b0);
		rd_chk(USC_OFF_CSA, 32'h98, 32'h90);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'h81);
		// nine-bit frames: ninth bit written and read before the data byte
		wr(USC_OFF_CSB, 32'h1D);
		wr(USC_OFF_DATA, 32'h12);
		tx_chk(9'h112, 9, 32);
		usc_far_end_inst.send_async(9'h1C3, 9, 32, 1'b1);
		rd_chk(USC_OFF_CSB, 32'h02, 32'h02);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'hC3);
		wr(USC_OFF_CSB, 32'h18);
		// double speed: 8 * 2 clocks a bit both ways
		wr(USC_OFF_CSA, 32'h02);
		wr(USC_OFF_DATA, 32'h4E);
		tx_chk(9'h04E, 8, 16);
		usc_far_end_inst.send_async(9'h06B, 8, 16, 1'b1);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'h6B);
		// synchronous master: clock period 2 * 2 clocks, driven out of the pin
		wr(USC_OFF_CSA, 32'h00);
		wr(USC_OFF_CSC, 32'h40);
		wr(USC_OFF_PINDIR, 32'h01);
		@(posedge clk_i);
		chk({31'h0, xck_oe_n}, 32'h0);
		wr(USC_OFF_DATA, 32'h33);
		n = 0;
		wait_xck(1'b1, n);
		wait_xck(1'b0, n);
		m = n;
		wait_xck(1'b1, n);
		wait_xck(1'b0, n);
		chk(n - m, 32'd4);
		repeat (80) @(posedge clk_i);
		// synchronous slave: remote clock of 16 system clocks, well below a quarter
		wr(USC_OFF_PINDIR, 32'h00);
		@(posedge clk_i);
		chk({31'h0, xck_oe_n}, 32'h1);
		usc_far_end_inst.send_sync(8'hC5, 8);
		rd_chk(USC_OFF_DATA, 32'hFF, 32'hC5);
		// direction says output, but async mode must leave the pin alone
		wr(USC_OFF_PINDIR, 32'h01);
		wr(USC_OFF_CSC, 32'h00);
		@(posedge clk_i);
		chk({31'h0, xck_oe_n}, 32'h1);
		wrap_up();
	end
endmodule
